// ===== verilog/trc_top.sv
// Trigger receiver register bank with timing windows and event counters.
module trc_top (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [trc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [trc_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [trc_pkg::DATA_W-1:0] o_rd_data,
    input wire logic i_trigger_level_zero,
    input wire logic i_trigger_level_one,
    input wire logic i_orbit_start_marker,
    input wire logic i_prepulse_ok,
    input wire logic i_l1_msg_ok,
    input wire logic i_l2a_msg_ok,
    input wire logic i_l2r_msg_ok,
    input wire logic i_roi_msg_ok,
    output logic o_test_level_zero,
    output logic o_test_level_one,
    output logic o_test_busy,
    output logic o_l1_msg_window_err,
    output logic o_l2_msg_window_err,
    output logic o_roi_msg_window_err,
    output logic o_l1_trig_window_err
);
    import trc_pkg::*;

    localparam logic [5:0] STEP = 6'(CLK_PERIOD_NS);
    localparam logic [5:0] TICK = 6'(TICK_NS);
    localparam logic [WIN_W-1:0] WIN_SAT = '1;
    localparam logic [L0T_W-1:0] L0T_SAT = '1;

    // The tick accumulator keeps remainders below the tick length in five bits and adds
    // one clock period per cycle, so the clock must be faster than the tick and divide
    // a microsecond evenly; other clock rates need a wider accumulator.
    if (CLK_PERIOD_NS < 1 || CLK_PERIOD_NS >= TICK_NS || TICK_NS > 31 ||
        CLK_PERIOD_NS * CLK_MHZ != 1000) begin : g_bad_tick
        $error("trc_top: clock period does not fit the tick accumulator");
    end

    // The delay counter must reach the largest expected delay plus tolerance, and the
    // window fields must match the orbit time width they are compared with.
    if (L0T_W < EXP_MSB - EXP_LSB + 2 || WIN_W != MAX_MSB - MAX_LSB + 1 ||
        WIN_W != MIN_MSB - MIN_LSB + 1) begin : g_bad_win
        $error("trc_top: window fields and delay counter widths disagree");
    end

    // Read data is zero-extended, so no register may be wider than the data bus.
    if (CNT_W > DATA_W || BC_W > DATA_W || MIN_MSB >= DATA_W) begin : g_bad_data
        $error("trc_top: register wider than the data bus");
    end

    typedef struct packed {
        logic [NUM_PIN-1:0] s1;
        logic [NUM_PIN-1:0] s2;
        logic [NUM_PIN-1:0] s3;
        logic [NUM_PIN-1:0] lvl;
        logic [4:0] frac;
        logic [BC_W-1:0] bc;
        logic [WIN_W-1:0] orbit_t;
        logic [L0T_W-1:0] l0_t;
        logic l0_seen;
        logic [15:0] l1_win;
        logic [31:0] l2_win;
        logic [31:0] roi_win;
        logic [31:0] l1m_win;
        logic [BC_W-1:0] bcid_l1;
        logic [NUM_ERR-1:0] err;
        trc_test_e test_st;
        logic [L0T_W-1:0] test_t;
        logic test_l0;
        logic test_l1;
        logic test_busy;
        logic [DATA_W-1:0] rd_data;
    } trc_state_s;

    trc_state_s q;
    trc_state_s d;

    trc_tally_if #(.N(NUM_CH), .W(CNT_W)) tally_bus ();

    trc_tally #(
        .N(NUM_CH),
        .W(CNT_W)
    ) u_tally (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .bus(tally_bus)
    );

    logic [NUM_PIN-1:0] pin_in;
    logic [NUM_PIN-1:0] lvl_nxt;
    logic [NUM_PIN-1:0] rise;
    logic [5:0] frac_sum;
    logic tick;
    logic ev_l0;
    logic ev_l1;
    logic ev_orbit;
    logic wr_clr;
    logic wr_test;
    logic [L0T_W-1:0] exp_t;
    logic [L0T_W-1:0] tol_t;
    logic [L0T_W-1:0] lo_t;
    logic [L0T_W-1:0] hi_t;
    logic [NUM_ERR-1:0] err_set;
    logic [DATA_W-1:0] rd_nxt;

    assign pin_in[PIN_L0] = i_trigger_level_zero;
    assign pin_in[PIN_L1] = i_trigger_level_one;
    assign pin_in[PIN_ORBIT] = i_orbit_start_marker;

    // A pin level is accepted only once the second and third stages agree.
    for (genvar g = 0; g < NUM_PIN; g++) begin : g_pin
        assign lvl_nxt[g] = (q.s2[g] == q.s3[g]) ? q.s2[g] : q.lvl[g];
        assign rise[g] = lvl_nxt[g] & ~q.lvl[g];
    end

    // Both triggers may also come from the test sequence, so the tallies see them too.
    assign ev_l0 = rise[PIN_L0] | q.test_l0;
    assign ev_l1 = rise[PIN_L1] | q.test_l1;
    assign ev_orbit = rise[PIN_ORBIT];

    assign wr_clr = i_wr && (i_addr == ADDR_CNT_CLR);
    assign wr_test = i_wr && (i_addr == ADDR_TEST_SEQ);

    // A 25 ns tick from a 4 ns clock: a remainder accumulator keeps the mean rate exact.
    assign frac_sum = {1'b0, q.frac} + STEP;
    assign tick = (frac_sum >= TICK);

    assign exp_t = L0T_W'(q.l1_win[EXP_MSB:EXP_LSB]);
    assign tol_t = L0T_W'(q.l1_win[TOL_MSB:TOL_LSB]);
    assign lo_t = (exp_t > tol_t) ? exp_t - tol_t : '0;
    assign hi_t = exp_t + tol_t;

    // The message inputs are not gated during the test sequence; software keeps the
    // serial channel off meanwhile, otherwise real messages mix into the tallies.
    always_comb begin
        tally_bus.clr = wr_clr;
        tally_bus.inc = '0;
        tally_bus.inc[CH_PREPULSE] = i_prepulse_ok;
        tally_bus.inc[CH_L0] = ev_l0;
        tally_bus.inc[CH_L1] = ev_l1;
        tally_bus.inc[CH_L1M] = i_l1_msg_ok;
        tally_bus.inc[CH_L2A] = i_l2a_msg_ok;
        tally_bus.inc[CH_L2R] = i_l2r_msg_ok;
        tally_bus.inc[CH_ROI] = i_roi_msg_ok;
    end

    // Message arrival checks against the orbit-relative time at the moment of decoding; the level-one trigger check uses the time since level-zero.
    always_comb begin
        err_set = '0;
        if (i_l1_msg_ok) begin
            if (q.orbit_t < q.l1m_win[MIN_MSB:MIN_LSB] ||
                q.orbit_t > q.l1m_win[MAX_MSB:MAX_LSB]) begin
                err_set[ERR_L1M] = 1'b1;
            end
        end
        if (i_l2a_msg_ok || i_l2r_msg_ok) begin
            if (q.orbit_t < q.l2_win[MIN_MSB:MIN_LSB] ||
                q.orbit_t > q.l2_win[MAX_MSB:MAX_LSB]) begin
                err_set[ERR_L2] = 1'b1;
            end
        end
        if (i_roi_msg_ok) begin
            if (q.orbit_t < q.roi_win[MIN_MSB:MIN_LSB] ||
                q.orbit_t > q.roi_win[MAX_MSB:MAX_LSB]) begin
                err_set[ERR_ROI] = 1'b1;
            end
        end
        if (ev_l1) begin
            if (!q.l0_seen || q.l0_t < lo_t || q.l0_t > hi_t) begin
                err_set[ERR_L1T] = 1'b1;
            end
        end
    end

    // Read decode; writes to counter addresses fall through and change nothing.
    always_comb begin
        rd_nxt = '0;
        if (i_addr == ADDR_L1_WIN) begin
            rd_nxt = DATA_W'(q.l1_win);
        end else if (i_addr == ADDR_L2_WIN) begin
            rd_nxt = q.l2_win;
        end else if (i_addr == ADDR_ROI_WIN) begin
            rd_nxt = q.roi_win;
        end else if (i_addr == ADDR_L1M_WIN) begin
            rd_nxt = q.l1m_win;
        end else if (i_addr == ADDR_PREPULSE) begin
            rd_nxt = DATA_W'(tally_bus.cnt[CH_PREPULSE]);
        end else if (i_addr == ADDR_BCID_L1) begin
            rd_nxt = DATA_W'(q.bcid_l1);
        end else if (i_addr == ADDR_L0_TALLY) begin
            rd_nxt = DATA_W'(tally_bus.cnt[CH_L0]);
        end else if (i_addr == ADDR_L1_TALLY) begin
            rd_nxt = DATA_W'(tally_bus.cnt[CH_L1]);
        end else if (i_addr == ADDR_L1M_TALLY) begin
            rd_nxt = DATA_W'(tally_bus.cnt[CH_L1M]);
        end else if (i_addr == ADDR_L2A_TALLY) begin
            rd_nxt = DATA_W'(tally_bus.cnt[CH_L2A]);
        end else if (i_addr == ADDR_L2R_TALLY) begin
            rd_nxt = DATA_W'(tally_bus.cnt[CH_L2R]);
        end else if (i_addr == ADDR_ROI_TALLY) begin
            rd_nxt = DATA_W'(tally_bus.cnt[CH_ROI]);
        end else if (i_addr == ADDR_FREE_BC) begin
            rd_nxt = DATA_W'(q.bc);
        end
    end

    always_comb begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.lvl = lvl_nxt;
        d.frac = tick ? 5'(frac_sum - TICK) : frac_sum[4:0];
        d.test_l0 = 1'b0;
        d.test_l1 = 1'b0;
        d.rd_data = i_rd ? rd_nxt : '0;

        if (tick) begin
            d.bc = q.bc + 1'b1;
        end

        // Orbit time saturates rather than wrapping, so a lost orbit marker makes late
        // messages flag instead of passing as early ones.
        if (ev_orbit) begin
            d.orbit_t = '0;
        end else if (tick && q.orbit_t != WIN_SAT) begin
            d.orbit_t = q.orbit_t + 1'b1;
        end

        // A level-one trigger consumes the pending level-zero; a second level-one
        // without a new level-zero is then flagged as unmatched.
        if (ev_l0) begin
            d.l0_t = '0;
            d.l0_seen = 1'b1;
        end else if (ev_l1) begin
            d.l0_seen = 1'b0;
        end else if (tick && q.l0_t != L0T_SAT) begin
            d.l0_t = q.l0_t + 1'b1;
        end

        // The capture takes the count before this cycle's tick, that is the crossing in
        // which the trigger was seen.
        if (ev_l1) begin
            d.bcid_l1 = q.bc;
        end

        // A new error in the clearing cycle wins over the clear.
        if (wr_clr) begin
            d.err = err_set;
        end else begin
            d.err = q.err | err_set;
        end

        if (i_wr) begin
            if (i_addr == ADDR_L1_WIN) begin
                d.l1_win = i_wr_data[15:0];
            end else if (i_addr == ADDR_L2_WIN) begin
                d.l2_win = i_wr_data;
            end else if (i_addr == ADDR_ROI_WIN) begin
                d.roi_win = i_wr_data;
            end else if (i_addr == ADDR_L1M_WIN) begin
                d.l1m_win = i_wr_data;
            end
        end

        // Test sequence: one level-zero pulse, then a level-one pulse after the
        // programmed expected delay. A strobe while busy is ignored.
        case (q.test_st)
            TS_IDLE: begin
                if (wr_test) begin
                    d.test_l0 = 1'b1;
                    d.test_t = '0;
                    d.test_st = TS_WAIT;
                    d.test_busy = 1'b1;
                end
            end
            TS_WAIT: begin
                if (tick) begin
                    if (q.test_t >= exp_t) begin
                        d.test_l1 = 1'b1;
                        d.test_st = TS_IDLE;
                        d.test_busy = 1'b0;
                    end else begin
                        d.test_t = q.test_t + 1'b1;
                    end
                end
            end
            default: begin
                d.test_st = TS_IDLE;
                d.test_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q <= '0;
            q.l1_win <= {L1_TOL_RST, L1_EXP_RST};
            q.l2_win <= {L2_MIN_RST, L2_MAX_RST};
            q.roi_win <= {ROI_MIN_RST, ROI_MAX_RST};
            q.l1m_win <= {L1M_MIN_RST, L1M_MAX_RST};
            q.test_st <= TS_IDLE;
        end else begin
            q <= d;
        end
    end

    // Writes to the tally and crossing capture addresses are decoded nowhere; the tallies
    // change only by counting and the clear, the capture only on a level-one trigger.
    assign o_rd_data = q.rd_data;
    assign o_test_level_zero = q.test_l0;
    assign o_test_level_one = q.test_l1;
    assign o_test_busy = q.test_busy;
    assign o_l1_msg_window_err = q.err[ERR_L1M];
    assign o_l2_msg_window_err = q.err[ERR_L2];
    assign o_roi_msg_window_err = q.err[ERR_ROI];
    assign o_l1_trig_window_err = q.err[ERR_L1T];
endmodule // trc_top

// ===== verilog/trc_pkg.sv
// Package with register map, field layout, reset values and timing constants.
package trc_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int BC_W = 12;
    localparam int WIN_W = 16;
    localparam int L0T_W = 13;

    localparam logic [15:0] ADDR_CNT_CLR = 16'h4004;
    localparam logic [15:0] ADDR_TEST_SEQ = 16'h4005;
    localparam logic [15:0] ADDR_L1_WIN = 16'h4006;
    localparam logic [15:0] ADDR_L2_WIN = 16'h4007;
    localparam logic [15:0] ADDR_ROI_WIN = 16'h4009;
    localparam logic [15:0] ADDR_L1M_WIN = 16'h400a;
    localparam logic [15:0] ADDR_PREPULSE = 16'h400b;
    localparam logic [15:0] ADDR_BCID_L1 = 16'h400c;
    localparam logic [15:0] ADDR_L0_TALLY = 16'h400d;
    localparam logic [15:0] ADDR_L1_TALLY = 16'h400e;
    localparam logic [15:0] ADDR_L1M_TALLY = 16'h400f;
    localparam logic [15:0] ADDR_L2A_TALLY = 16'h4010;
    localparam logic [15:0] ADDR_L2R_TALLY = 16'h4011;
    localparam logic [15:0] ADDR_ROI_TALLY = 16'h4012;
    localparam logic [15:0] ADDR_FREE_BC = 16'h4013;

    // Field positions inside the window registers.
    localparam int EXP_LSB = 0;
    localparam int EXP_MSB = 11;
    localparam int TOL_LSB = 12;
    localparam int TOL_MSB = 15;
    localparam int MAX_LSB = 0;
    localparam int MAX_MSB = 15;
    localparam int MIN_LSB = 16;
    localparam int MIN_MSB = 31;

    localparam logic [11:0] L1_EXP_RST = 12'h0d4;
    localparam logic [3:0] L1_TOL_RST = 4'h2;
    localparam logic [15:0] L2_MAX_RST = 16'h4e20;
    localparam logic [15:0] L2_MIN_RST = 16'h0c80;
    localparam logic [15:0] ROI_MAX_RST = 16'hffff;
    localparam logic [15:0] ROI_MIN_RST = 16'h0000;
    localparam logic [15:0] L1M_MAX_RST = 16'h0028;
    localparam logic [15:0] L1M_MIN_RST = 16'h00f8;

    // Latency fields count bunch-crossing ticks; the tick is not a whole number of clocks.
    localparam int CLK_MHZ = 250;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int TICK_NS = 25;

    localparam int CH_PREPULSE = 0;
    localparam int CH_L0 = 1;
    localparam int CH_L1 = 2;
    localparam int CH_L1M = 3;
    localparam int CH_L2A = 4;
    localparam int CH_L2R = 5;
    localparam int CH_ROI = 6;
    localparam int NUM_CH = 7;

    localparam int ERR_L1M = 0;
    localparam int ERR_L2 = 1;
    localparam int ERR_ROI = 2;
    localparam int ERR_L1T = 3;
    localparam int NUM_ERR = 4;

    localparam int PIN_L0 = 0;
    localparam int PIN_L1 = 1;
    localparam int PIN_ORBIT = 2;
    localparam int NUM_PIN = 3;

    typedef enum logic [1:0] {TS_IDLE, TS_WAIT} trc_test_e;
endpackage

// ===== verilog/trc_tally_if.sv
// Interface joining the register bank and its event counter block.
interface trc_tally_if #(parameter int N = 7, parameter int W = 16);
    logic [N-1:0] inc;
    logic clr;
    logic [N-1:0][W-1:0] cnt;
    modport ctl (output inc, output clr, input cnt);
    modport tally (input inc, input clr, output cnt);
endinterface

// ===== verilog/trc_tally.sv
// Bank of wrapping event counters with a common clear.
module trc_tally #(
    parameter int N = 7,
    parameter int W = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    trc_tally_if.tally bus
);
    typedef struct packed {
        logic [N-1:0][W-1:0] cnt;
    } trc_tally_s;

    trc_tally_s q;
    trc_tally_s d;
    logic [N-1:0][W-1:0] nxt;

    if (N < 1 || W < 1 || W > 32) begin : g_bad
        $error("trc_tally: unsupported N or W");
    end

    for (genvar g = 0; g < N; g++) begin : g_ch
        // An event in the clearing cycle still counts, so it is never lost.
        assign nxt[g] = bus.clr ? W'(bus.inc[g]) : q.cnt[g] + W'(bus.inc[g]);
    end

    always_comb begin
        d = q;
        d.cnt = nxt;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.cnt = q.cnt;
endmodule // trc_tally

// ===== tb/trc_partner.sv
// Model of the central trigger system driving trigger pins and decoded message pulses.
module trc_partner (
    input wire logic i_ref_clk,
    output logic [trc_pkg::NUM_PIN-1:0] o_pin,
    output logic [4:0] o_msg
);
    timeunit 1ns;
    timeprecision 100ps;
    import trc_pkg::*;
    initial begin
        o_pin = '0;
        o_msg = '0;
    end
    // Pins are held for several clocks so the receiver's synchroniser sees a stable level.
    task automatic pin_pulse(input int idx);
        @(posedge i_ref_clk) o_pin[idx] <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        o_pin[idx] <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
    endtask
    task automatic msg_pulse(input int idx);
        @(posedge i_ref_clk) o_msg[idx] <= 1'b1;
        @(posedge i_ref_clk) o_msg[idx] <= 1'b0;
    endtask
endmodule // trc_partner

// ===== tb/trc_checker.sv
// Checker of bus reply, test sequence and window flag timing at the register bank ports.
module trc_checker (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [trc_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [trc_pkg::DATA_W-1:0] o_rd_data,
    input wire logic i_l1_msg_ok,
    input wire logic i_l2a_msg_ok,
    input wire logic i_l2r_msg_ok,
    input wire logic o_test_level_zero,
    input wire logic o_test_level_one,
    input wire logic o_test_busy,
    input wire logic o_l1_msg_window_err,
    input wire logic o_l2_msg_window_err
);
    timeunit 1ns;
    timeprecision 100ps;
    import trc_pkg::*;
    logic clr;
    logic l2;
    assign clr = i_wr && i_addr == ADDR_CNT_CLR;
    assign l2 = i_l2a_msg_ok || i_l2r_msg_ok;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_rd_idle_zero: assert property (!i_rd |=> o_rd_data == '0)
        else $error("read data not zero outside a reply");
    a_wo_read_zero: assert property (i_rd && (i_addr == ADDR_CNT_CLR ||
        i_addr == ADDR_TEST_SEQ || i_addr == 16'h4008) |=> o_rd_data == '0)
        else $error("strobe or unmapped read not zero");
    a_test_start: assert property (i_wr && i_addr == ADDR_TEST_SEQ && !o_test_busy
        |=> o_test_level_zero ##[0:1] o_test_busy) else $error("test start missing");
    a_test_refused: assert property (i_wr && i_addr == ADDR_TEST_SEQ && o_test_busy
        |=> !o_test_level_zero) else $error("test restarted while busy");
    a_l0_one_cycle: assert property (o_test_level_zero |=> !o_test_level_zero)
        else $error("test L0 pulse too long");
    a_l1_ends_busy: assert property (o_test_level_one |-> $past(o_test_busy)
        ##1 (!o_test_busy && !o_test_level_one)) else $error("test end wrong");
    a_l1m_err_cause: assert property ($rose(o_l1_msg_window_err) |-> $past(i_l1_msg_ok))
        else $error("L1 message flag without message");
    a_l2_err_cause: assert property ($rose(o_l2_msg_window_err) |-> $past(l2))
        else $error("L2 flag without message");
    a_l1m_err_hold: assert property (o_l1_msg_window_err && !clr |=> o_l1_msg_window_err)
        else $error("L1 message flag dropped");
    a_l2_err_hold: assert property (o_l2_msg_window_err && !clr |=> o_l2_msg_window_err)
        else $error("L2 flag dropped");
    a_clr_err: assert property (clr && !i_l1_msg_ok && !l2 |=>
        !o_l1_msg_window_err && !o_l2_msg_window_err) else $error("flags not cleared");
    c_test: cover property (o_test_level_one);
    c_l1m_err: cover property ($rose(o_l1_msg_window_err));
    c_clr: cover property (clr && o_l2_msg_window_err);
endmodule // trc_checker
bind trc_top trc_checker chk_u (.*);

// ===== tb/trc_top_tb.sv
// Self-checking bench of the trigger receiver register bank.
module trc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import trc_pkg::*;
    logic i_ref_clk, i_rst, i_wr, i_rd;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wr_data;
    logic [DATA_W-1:0] o_rd_data;
    logic [NUM_PIN-1:0] pin;
    logic [4:0] msg;
    logic t0, t1, busy;
    logic [3:0] err;
    int fail_count, tests_run;
    trc_top dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
        .i_trigger_level_zero(pin[PIN_L0]), .i_trigger_level_one(pin[PIN_L1]),
        .i_orbit_start_marker(pin[PIN_ORBIT]), .i_prepulse_ok(msg[0]),
        .i_l1_msg_ok(msg[1]), .i_l2a_msg_ok(msg[2]), .i_l2r_msg_ok(msg[3]),
        .i_roi_msg_ok(msg[4]), .o_test_level_zero(t0), .o_test_level_one(t1),
        .o_test_busy(busy), .o_l1_msg_window_err(err[0]), .o_l2_msg_window_err(err[1]),
        .o_roi_msg_window_err(err[2]), .o_l1_trig_window_err(err[3]));
    trc_partner far_u (.i_ref_clk(i_ref_clk), .o_pin(pin), .o_msg(msg));
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic chk_bit(input logic exp, input logic got);
        chk_reg({31'h0, exp}, {31'h0, got});
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rd_data;
    endtask
    task automatic rck(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk_reg(exp, v);
    endtask
    // The crossing capture register is left out: its value depends on synchroniser phase.
    task automatic zero_tallies();
        for (int a = 16'h400b; a <= 16'h4012; a++) begin
            if (a != 16'h400c) rck(16'(a), 32'h0);
        end
    endtask
    initial begin
        logic [31:0] f;
        logic [31:0] g;
        int n;
        fail_count = 0;
        tests_run = 0;
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = '0;
        i_wr_data = '0;
        repeat (16) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rck(ADDR_L1_WIN, 32'h000020d4);
        rck(ADDR_L2_WIN, 32'h0c804e20);
        rck(ADDR_ROI_WIN, {ROI_MIN_RST, ROI_MAX_RST});
        rck(ADDR_L1M_WIN, 32'h00f80028);
        zero_tallies();
        wr(ADDR_ROI_WIN, 32'h1234abcd);
        rck(ADDR_ROI_WIN, 32'h1234abcd);
        wr(ADDR_L1_WIN, 32'hffff2010);
        rck(ADDR_L1_WIN, 32'h00002010);
        wr(16'h4008, 32'hffffffff);
        rck(16'h4008, 32'h0);
        rck(ADDR_CNT_CLR, 32'h0);
        for (int k = 0; k < 5; k++) begin
            for (int j = 0; j <= k; j++) far_u.msg_pulse(k);
        end
        repeat (3) far_u.pin_pulse(PIN_L0);
        repeat (2) far_u.pin_pulse(PIN_L1);
        for (int k = 0; k < 5; k++) begin
            rck(k == 0 ? ADDR_PREPULSE : ADDR_L1_TALLY + 16'(k), k + 1);
        end
        rck(ADDR_L0_TALLY, 32'h3);
        rck(ADDR_L1_TALLY, 32'h2);
        chk_bit(1'b1, err[0]);
        chk_bit(1'b1, err[2]);
        chk_bit(1'b1, err[3]);
        wr(ADDR_L0_TALLY, 32'hffff);
        rck(ADDR_L0_TALLY, 32'h3);
        rd(ADDR_FREE_BC, f);
        // 250 clocks of 4 ns span exactly 40 ticks of 25 ns.
        repeat (248) @(posedge i_ref_clk);
        rck(ADDR_FREE_BC, (f + 32'd40) & 32'hfff);
        wr(ADDR_CNT_CLR, 32'h0);
        zero_tallies();
        chk_bit(1'b0, err[0]);
        chk_bit(1'b0, err[2]);
        chk_bit(1'b0, err[3]);
        far_u.pin_pulse(PIN_ORBIT);
        wr(ADDR_L2_WIN, 32'h0000ffff);
        wr(ADDR_L1M_WIN, 32'h0000ffff);
        far_u.msg_pulse(2);
        far_u.msg_pulse(1);
        repeat (3) @(posedge i_ref_clk);
        #1 chk_bit(1'b0, err[1]);
        chk_bit(1'b0, err[0]);
        wr(ADDR_L2_WIN, 32'hff00ffff);
        far_u.msg_pulse(3);
        repeat (3) @(posedge i_ref_clk);
        #1 chk_bit(1'b1, err[1]);
        rck(ADDR_L1M_TALLY, 32'h1);
        // No serial messages are sent while the test sequence runs.
        wr(ADDR_TEST_SEQ, 32'h0);
        #1 chk_bit(1'b1, t0);
        @(posedge i_ref_clk) #1 chk_bit(1'b1, busy);
        wr(ADDR_TEST_SEQ, 32'h1);
        for (n = 0; n < 2000 && t1 !== 1'b1; n++) @(posedge i_ref_clk) #1;
        if (n == 2000) begin
            fail_count++;
        end else begin
            @(posedge i_ref_clk) #1 chk_bit(1'b0, busy);
            // Ticks are at least six clocks apart, so the capture trails this read by one at most.
            rd(ADDR_FREE_BC, f);
            rd(ADDR_BCID_L1, g);
            chk_bit(1'b1, g == f || g == ((f - 32'd1) & 32'hfff));
            rck(ADDR_L0_TALLY, 32'h1);
            rck(ADDR_L1_TALLY, 32'h1);
            chk_bit(1'b0, err[3]);
        end
        complete_run();
    end
endmodule // trc_top_tb
